// *** common/rvmc_map.svh ***
// Register map constants for the video-mode control register
`ifndef RVMC_MAP_SVH
`define RVMC_MAP_SVH
`define RVMC_ADDR_W 8
`define RVMC_OFS_CTRL6 8'h0F
`define RVMC_RESET_VAL 16'h0024
`define RVMC_WR_MASK 16'hE1FF
`define RVMC_BIT_VSP 15
`define RVMC_BIT_HSP 14
`define RVMC_BIT_PCLKP 13
`define RVMC_BIT_CBM 8
`define RVMC_BIT_NVB 7
`define RVMC_BIT_NVD 6
`define RVMC_BIT_BLANK 5
`define RVMC_BIT_VCS 4
`define RVMC_VM_HI 3
`define RVMC_VM_LO 2
`define RVMC_PF_HI 1
`define RVMC_PF_LO 0
`define RVMC_VM_BURST 2'h2
`define RVMC_RSV_HI 12
`define RVMC_RSV_LO 9
`define RVMC_LANE0_HI 7
`endif

// *** common/rvmc_pkg.sv ***
// Types for the video-mode control register block
package rvmc_pkg;
    typedef enum logic [1:0] {
        RVMC_LINK_HS,
        RVMC_LINK_LP
    } rvmc_link_t;
endpackage

// *** rtl/rvmc_video_mode_ctrl.sv ***
// Video-mode control register with Avalon-MM slave and decoded link controls
//
// Behaviour
// - One 16-bit read/write register at 0xF
// - Bit 15 sets vertical sync polarity
// - Bit 14 sets horizontal sync polarity
// - Bit 13 selects pixel clock sampling edge
// - Bit 7 limits burst non-video to vblank
// - Send host non-video data in allowed intervals
// - Bit 6 selects HS or LP non-video
// - Bit 5 blanking or LP, non-burst with bit 6 clear only
// - Burst mode blanking intervals use low power
// - Bit 4 idle clock lane suspend, burst only
`timescale 1ns/1ps
`default_nettype none
`include "rvmc_map.svh"

module rvmc_video_mode_ctrl (
    // Clock, reset, enable
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Avalon-MM slave
    input wire logic [`RVMC_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Video timing pins from the source
    input wire logic vsync_pin,
    input wire logic hsync_pin,
    // Link interval context from the transmitter
    input wire logic vblank_active,
    input wire logic blank_interval,
    input wire logic nonvideo_pending,
    // Decoded controls
    output logic vsync_active,
    output logic hsync_active,
    output logic pclk_sample_falling,
    output logic send_blanking_pkt,
    output logic compressed_burst,
    output logic nonvideo_send_ok,
    output rvmc_pkg::rvmc_link_t nonvideo_link,
    output logic blank_use_lp,
    output logic clock_lane_lp
);
    import rvmc_pkg::*;

    logic [15:0] video_interface_control_six;
    logic ack;
    logic vs_s1, vs_s2, hs_s1, hs_s2;
    logic burst;
    logic hit;

    assign hit = (avs_address == `RVMC_OFS_CTRL6);
    assign burst = (video_interface_control_six[`RVMC_VM_HI:`RVMC_VM_LO] == `RVMC_VM_BURST);

    // One wait cycle per access; ack answers the held request
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ack <= 1'b0;
        end else if (clk_en) begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !(ack && clk_en); // Stalls while frozen

    // Register write, per byte lane; reserved bits never stored
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            video_interface_control_six <= `RVMC_RESET_VAL;
        end else if (clk_en && avs_write && ack && hit) begin
            for (int b = 0; b < 2; b++) begin
                if (avs_byteenable[b]) begin
                    video_interface_control_six[b*8 +: 8] <=
                        avs_writedata[b*8 +: 8] & 8'(`RVMC_WR_MASK >> (b*8));
                end
            end
        end
    end

    // Read data registered; unmapped addresses read zero
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en && avs_read && !ack) begin
            avs_readdata <= hit ? {16'h0000, video_interface_control_six & `RVMC_WR_MASK}
                                : 32'h0000_0000;
        end
    end

    // Sync pins are asynchronous: two flops before use
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vs_s1 <= 1'b0;
            vs_s2 <= 1'b0;
            hs_s1 <= 1'b0;
            hs_s2 <= 1'b0;
        end else if (clk_en) begin
            vs_s1 <= vsync_pin;
            vs_s2 <= vs_s1;
            hs_s1 <= hsync_pin;
            hs_s2 <= hs_s1;
        end
    end

    // Decoded controls, registered so outputs come from flops
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            vsync_active <= 1'b0;
            hsync_active <= 1'b0;
            pclk_sample_falling <= 1'b0;
            compressed_burst <= 1'b0;
            send_blanking_pkt <= 1'b0;
            nonvideo_send_ok <= 1'b0;
            nonvideo_link <= RVMC_LINK_HS;
            blank_use_lp <= 1'b0;
            clock_lane_lp <= 1'b0;
        end else if (clk_en) begin
            // Polarity 1 means active high
            vsync_active <= ~(vs_s2 ^ video_interface_control_six[`RVMC_BIT_VSP]);
            hsync_active <= ~(hs_s2 ^ video_interface_control_six[`RVMC_BIT_HSP]);
            pclk_sample_falling <= video_interface_control_six[`RVMC_BIT_PCLKP];
            compressed_burst <= burst && video_interface_control_six[`RVMC_BIT_CBM];
            // Non-video window: vblank only, unless burst with interleave 0
            nonvideo_send_ok <= nonvideo_pending &&
                (burst ? (video_interface_control_six[`RVMC_BIT_NVB] ? vblank_active : blank_interval)
                       : vblank_active);
            nonvideo_link <= video_interface_control_six[`RVMC_BIT_NVD] ? RVMC_LINK_LP : RVMC_LINK_HS;
            // Burst forces LP; NONVIDEO_LINK_MODE=1 forces LP; else bit 5 decides
            blank_use_lp <= burst || video_interface_control_six[`RVMC_BIT_NVD] ||
                            video_interface_control_six[`RVMC_BIT_BLANK];
            send_blanking_pkt <= blank_interval && !burst && !video_interface_control_six[`RVMC_BIT_NVD] &&
                                 !video_interface_control_six[`RVMC_BIT_BLANK];
            // Non-burst keeps the clock lane in HS always
            clock_lane_lp <= burst && video_interface_control_six[`RVMC_BIT_VCS] &&
                             blank_interval && !nonvideo_pending;
        end
    end

    // Assertions
    property p_reserved_zero;
        @(posedge core_clk) disable iff (!nrst)
        video_interface_control_six[`RVMC_RSV_HI:`RVMC_RSV_LO] == 4'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

    property p_write_lands;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && avs_write && ack && hit && (&avs_byteenable[1:0]))
        |=> video_interface_control_six == ($past(avs_writedata[15:0]) & `RVMC_WR_MASK);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write not stored");

    property p_vs_pol;
        @(posedge core_clk) disable iff (!nrst)
        (nrst && clk_en) |=> vsync_active == ~($past(vs_s2) ^ $past(video_interface_control_six[`RVMC_BIT_VSP]));
    endproperty
    a_vs_pol: assert property (p_vs_pol) else $error("vsync polarity wrong");

    property p_hs_pol;
        @(posedge core_clk) disable iff (!nrst)
        (nrst && clk_en) |=> hsync_active == ~($past(hs_s2) ^ $past(video_interface_control_six[`RVMC_BIT_HSP]));
    endproperty
    a_hs_pol: assert property (p_hs_pol) else $error("hsync polarity wrong");

    property p_pclk;
        @(posedge core_clk) disable iff (!nrst)
        (nrst && clk_en) |=> pclk_sample_falling == $past(video_interface_control_six[`RVMC_BIT_PCLKP]);
    endproperty
    a_pclk: assert property (p_pclk) else $error("pclk edge wrong");

    property p_cbm;
        @(posedge core_clk) disable iff (!nrst)
        compressed_burst |-> $past(burst);
    endproperty
    a_cbm: assert property (p_cbm) else $error("compression outside burst");

    property p_nvb;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && burst && video_interface_control_six[`RVMC_BIT_NVB] && !vblank_active) |=> !nonvideo_send_ok;
    endproperty
    a_nvb: assert property (p_nvb) else $error("non-video outside vblank");

    property p_nonburst_vblank;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && !burst && !vblank_active) |=> !nonvideo_send_ok;
    endproperty
    a_nonburst_vblank: assert property (p_nonburst_vblank) else $error("non-burst non-video off vblank");

    property p_nvd;
        @(posedge core_clk) disable iff (!nrst)
        (nrst && clk_en) |=> (nonvideo_link == RVMC_LINK_LP) == $past(video_interface_control_six[`RVMC_BIT_NVD]);
    endproperty
    a_nvd: assert property (p_nvd) else $error("non-video link mode wrong");

    property p_burst_lp;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && burst) |=> blank_use_lp && !send_blanking_pkt;
    endproperty
    a_burst_lp: assert property (p_burst_lp) else $error("burst blanking not LP");

    property p_clk_lane;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && !burst) |=> !clock_lane_lp;
    endproperty
    a_clk_lane: assert property (p_clk_lane) else $error("clock lane LP in non-burst");

    // A frozen enable must stall the bus, or a write would be lost
    property p_wait_frozen;
        @(posedge core_clk) disable iff (!nrst)
        (!clk_en && (avs_read || avs_write)) |-> avs_waitrequest;
    endproperty
    a_wait_frozen: assert property (p_wait_frozen) else $error("bus answered while frozen");

    property p_lane_hold;
        @(posedge core_clk) disable iff (!nrst)
        (clk_en && avs_write && ack && !avs_byteenable[0])
        |=> $stable(video_interface_control_six[`RVMC_LANE0_HI:`RVMC_PF_LO]);
    endproperty
    a_lane_hold: assert property (p_lane_hold) else $error("unselected byte lane changed");

endmodule // rvmc_video_mode_ctrl
`default_nettype wire

// *** tb/rvmc_src_model.sv ***
// Video source model that launches the sync pins
`timescale 1ns/1ps
`default_nettype none
module rvmc_src_model (
    // Clock and edge select
    input wire logic core_clk,
    input wire logic pclk_sample_falling,
    // Requested levels and pins
    input wire logic vs_req,
    input wire logic hs_req,
    output logic vsync_pin,
    output logic hsync_pin
);
    // Launch on the edge opposite the sampling edge, so pins settle before capture
    always @(posedge core_clk or negedge core_clk) begin
        if (core_clk == pclk_sample_falling) begin
            vsync_pin <= vs_req;
            hsync_pin <= hs_req;
        end
    end
endmodule // rvmc_src_model
`default_nettype wire

// *** tb/tb_rvmc_video_mode_ctrl.sv ***
// Self-checking bench for the video-mode control register
`timescale 1ns/1ps
`default_nettype none
`include "rvmc_map.svh"
module tb_rvmc_video_mode_ctrl;
    import rvmc_pkg::*;
    logic core_clk = 0, nrst = 0, clk_en = 1, avs_read = 0, avs_write = 0, vs_req = 0, b;
    logic vblank_active = 0, blank_interval = 0, nonvideo_pending = 0;
    logic [7:0] avs_address = 8'h00;
    logic [3:0] avs_byteenable = 4'hF;
    logic [15:0] c;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
    logic avs_waitrequest, vsync_pin, hsync_pin, vsync_active, hsync_active, pclk_sample_falling;
    logic send_blanking_pkt, compressed_burst, nonvideo_send_ok, blank_use_lp, clock_lane_lp;
    rvmc_link_t nonvideo_link;
    logic [15:0] cfgs [6] = '{16'h0024, 16'hE118, 16'h00D8, 16'h4100, 16'h8040, 16'hFFFF};
    int miscompares = 0, n_checks = 0;
    rvmc_video_mode_ctrl dut (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .vsync_pin(vsync_pin),
        .hsync_pin(hsync_pin), .vblank_active(vblank_active), .blank_interval(blank_interval),
        .nonvideo_pending(nonvideo_pending), .vsync_active(vsync_active), .hsync_active(hsync_active),
        .pclk_sample_falling(pclk_sample_falling), .send_blanking_pkt(send_blanking_pkt),
        .compressed_burst(compressed_burst), .nonvideo_send_ok(nonvideo_send_ok),
        .nonvideo_link(nonvideo_link), .blank_use_lp(blank_use_lp), .clock_lane_lp(clock_lane_lp));
    rvmc_src_model src (.core_clk(core_clk), .pclk_sample_falling(pclk_sample_falling),
        .vs_req(vs_req), .hs_req(!vs_req), .vsync_pin(vsync_pin), .hsync_pin(hsync_pin));
    // 125 MHz clock
    always #4 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic results();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // One transfer; edge gap first so back-to-back calls never drive a strobe twice
    task automatic bus(input logic rd, input logic [7:0] a, input logic [15:0] d);
        int n;
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= rd;
        avs_write <= !rd;
        avs_writedata <= {16'h0000, d};
        n = 0;
        // Waitrequest and read data are both taken at the rising edge
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 50);
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        if (n >= 50) begin
            miscompares++;
            results();
        end
    endtask
    // Reset, map checks, then every config against every interval context
    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'h1;
        bus(1'h1, `RVMC_OFS_CTRL6, 16'h0000);
        chk(q, 32'h0000_0024);
        bus(1'h1, 8'h10, 16'h0000);
        chk(q, 32'h0000_0000);
        // Upper lane only: low byte keeps its reset value
        avs_byteenable <= 4'h2;
        bus(1'h0, `RVMC_OFS_CTRL6, 16'hFFFF);
        avs_byteenable <= 4'hF;
        bus(1'h1, `RVMC_OFS_CTRL6, 16'h0000);
        chk(q, 32'h0000_E124);
        foreach (cfgs[i]) begin
            c = cfgs[i];
            bus(1'h0, `RVMC_OFS_CTRL6, c);
            bus(1'h0, 8'h0E, 16'h0000);
            bus(1'h1, `RVMC_OFS_CTRL6, 16'h0000);
            chk(q, {16'h0000, c & `RVMC_WR_MASK});
            b = (c[3:2] == `RVMC_VM_BURST);
            for (int x = 0; x < 16; x++) begin
                @(posedge core_clk);
                {vs_req, nonvideo_pending, blank_interval, vblank_active} <= x[3:0];
                repeat (4) @(posedge core_clk);
                @(negedge core_clk);
                chk(32'({vsync_active, hsync_active}), 32'({x[3] ~^ c[15], x[3] ^ c[14]}));
                chk(32'({pclk_sample_falling, nonvideo_link}), 32'({c[13], c[6] ? RVMC_LINK_LP : RVMC_LINK_HS}));
                chk(32'({send_blanking_pkt, compressed_burst, nonvideo_send_ok, blank_use_lp, clock_lane_lp}),
                    32'({x[1] & !b & !c[6] & !c[5], b & c[8], x[2] & (b ? (c[7] ? x[0] : x[1]) : x[0]),
                    b | c[6] | c[5], b & c[4] & x[1] & !x[2]}));
            end
        end
        // Frozen enable: outputs and the bus hold until it returns
        @(posedge core_clk);
        clk_en <= 1'h0;
        {vs_req, nonvideo_pending, blank_interval, vblank_active} <= 4'h0;
        fork
            bus(1'h1, `RVMC_OFS_CTRL6, 16'h0000);
            begin
                repeat (5) @(posedge core_clk);
                @(negedge core_clk);
                chk(32'(nonvideo_send_ok), 32'h0000_0001);
                @(posedge core_clk);
                clk_en <= 1'h1;
            end
        join
        chk(q, {16'h0000, 16'hFFFF & `RVMC_WR_MASK});
        @(negedge core_clk);
        chk(32'(nonvideo_send_ok), 32'h0000_0000);
        // Mid-run reset restores the default value
        @(posedge core_clk);
        nrst <= 1'h0;
        repeat (8) @(posedge core_clk);
        nrst <= 1'h1;
        bus(1'h1, `RVMC_OFS_CTRL6, 16'h0000);
        chk(q, {16'h0000, `RVMC_RESET_VAL});
        results();
    end
endmodule // tb_rvmc_video_mode_ctrl
`default_nettype wire
